// File: dv/adc_config_control_regs_tb_top.sv
// Self-checking bench of the converter control block.
// Assumes adcc_top, its package, the input model and the checker.
`timescale 1ns/1ps
`default_nettype none
module adc_config_control_regs_tb_top;
   logic        clk, rst, wr_s, rd_s, hw_trg, alt_clk, asy_clk;
   logic        conv_on, smp, cnv, lp, irq;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [11:0] level, res;
   logic [4:0]  chan;
   logic [1:0]  resol;
   logic [15:0] pins;
   int          num_errors = 0;
   int          n_compared = 0;
   int          s, c, k;

   adcc_top i_adcc_top (.core_clk_i(clk), .sys_rst_i(rst),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
      .reg_rd_i(rd_s), .reg_rdata_o(rdata), .hw_trigger_i(hw_trg),
      .alt_clk_i(alt_clk), .async_clk_i(asy_clk), .core_result_i(res),
      .conv_on_o(conv_on), .sample_o(smp), .convert_o(cnv),
      .channel_o(chan), .resolution_o(resol), .low_power_o(lp),
      .irq_o(irq), .pin_disable_o(pins));
   adcc_ana_model i_adcc_ana_model (.clk_i(clk), .conv_on_i(conv_on),
      .convert_i(cnv), .level_i(level), .result_o(res));

   // Bus clock and two unrelated input clocks
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      alt_clk = 1'b0;
      forever #35 alt_clk = ~alt_clk;
   end
   initial begin
      asy_clk = 1'b0;
      forever #55 asy_clk = ~asy_clk;
   end

   // Comparison and bus helpers
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task chk_rng(input int g, input int lo, input int hi);
      n_compared++;
      if (g < lo || g > hi) begin
         num_errors++;
         $display("ERROR %0t: count %0d", $time, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(16'(rdata), 16'(e));
   endtask
   // Counts sample and convert cycles of one conversion
   task run;
      s = 0;
      c = 0;
      for (k = 0; k < 3000; k++) begin
         @(posedge clk);
         #1;
         if (s > 0 && {smp, cnv} === 2'b00) break;
         s += int'(smp === 1'b1);
         c += int'(cnv === 1'b1);
      end
      chk_rng(k, 0, 2999);
   endtask
   // Counts busy cycles over a fixed span
   task watch(input int m);
      c = 0;
      repeat (m) begin
         @(posedge clk);
         #1;
         c += int'(smp === 1'b1 || cnv === 1'b1);
      end
   endtask

   // Scenarios
   task t_reset;
      rdc(adcc_pkg::OFS_SC1, 8'h1F);
      rdc(adcc_pkg::OFS_SC2, 8'h00);
      rdc(adcc_pkg::OFS_CFG, 8'h00);
      rdc(4'h9, 8'h00);
      chk(16'(conv_on), 16'h0000);
   endtask
   task t_single;
      wr(adcc_pkg::OFS_CFG, 8'h98);
      wr(adcc_pkg::OFS_SC2, 8'h7C);
      rdc(adcc_pkg::OFS_SC2, 8'h70);
      wr(adcc_pkg::OFS_SC2, 8'h00);
      rdc(adcc_pkg::OFS_CFG, 8'h98);
      chk({13'h0, lp, resol}, 16'h0006);
      wr(adcc_pkg::OFS_PIN1, 8'h02);
      chk(pins, 16'h0002);
      wr(adcc_pkg::OFS_PIN2, 8'h80);
      chk(pins, 16'h8002);
      wr(adcc_pkg::OFS_SC1, 8'h41);
      run;
      chk_rng(s, 24, 24);
      chk_rng(c, 12, 12);
      watch(2);
      chk(16'(irq), 16'h0001);
      rdc(adcc_pkg::OFS_SC1, 8'hC1);
      rdc(adcc_pkg::OFS_RESH, 8'h02);
      rdc(adcc_pkg::OFS_RESL, 8'h97);
      chk(16'(irq), 16'h0000);
      wr(adcc_pkg::OFS_SC1, 8'h9F);
      rdc(adcc_pkg::OFS_SC1, 8'h1F);
   endtask
   task t_active;
      wr(adcc_pkg::OFS_CFG, 8'h00);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      watch(1);
      rdc(adcc_pkg::OFS_SC2, 8'h80);
      run;
      chk_rng(c, 10, 10);
      rdc(adcc_pkg::OFS_SC2, 8'h00);
      rdc(adcc_pkg::OFS_SC1, 8'h81);
      chk(16'(irq), 16'h0000);
      rdc(adcc_pkg::OFS_RESH, 8'h00);
      rdc(adcc_pkg::OFS_RESL, 8'hA5);
   endtask
   task t_clocks;
      for (int d = 0; d < 4; d++) begin
         wr(adcc_pkg::OFS_CFG, 8'(d << 5));
         wr(adcc_pkg::OFS_SC1, 8'h01);
         run;
         chk_rng(s, 3 << d, 5 << d);
      end
      for (int d = 1; d < 4; d++) begin
         wr(adcc_pkg::OFS_CFG, 8'(d));
         wr(adcc_pkg::OFS_SC1, 8'h01);
         run;
         rdc(adcc_pkg::OFS_SC1, 8'h81);
      end
   endtask
   task t_cmp;
      wr(adcc_pkg::OFS_CFG, 8'h08);
      wr(adcc_pkg::OFS_CVH, 8'h00);
      wr(adcc_pkg::OFS_CVL, 8'h00);
      wr(adcc_pkg::OFS_SC2, 8'h20);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      rdc(adcc_pkg::OFS_SC1, 8'h01);
      wr(adcc_pkg::OFS_CVH, 8'h03);
      wr(adcc_pkg::OFS_CVL, 8'hFF);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      rdc(adcc_pkg::OFS_SC1, 8'h81);
      wr(adcc_pkg::OFS_SC2, 8'h30);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      rdc(adcc_pkg::OFS_SC1, 8'h01);
      wr(adcc_pkg::OFS_SC2, 8'h00);
   endtask
   task t_lock;
      wr(adcc_pkg::OFS_CFG, 8'h00);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      rdc(adcc_pkg::OFS_RESH, 8'h00);
      level = 12'h3C0;
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      rdc(adcc_pkg::OFS_SC1, 8'h01);
      rdc(adcc_pkg::OFS_RESL, 8'hA5);
      wr(adcc_pkg::OFS_CFG, 8'h04);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      run;
      chk_rng(c, 14, 14);
      rdc(adcc_pkg::OFS_RESH, 8'h03);
      rdc(adcc_pkg::OFS_RESL, 8'hC0);
   endtask
   task t_cont_hw;
      wr(adcc_pkg::OFS_SC1, 8'h21);
      watch(150);
      chk_rng(c, 60, 150);
      wr(adcc_pkg::OFS_SC1, 8'h3F);
      watch(60);
      chk_rng(c, 0, 0);
      wr(adcc_pkg::OFS_SC2, 8'h40);
      wr(adcc_pkg::OFS_SC1, 8'h01);
      watch(20);
      chk_rng(c, 0, 0);
      @(posedge clk) hw_trg <= 1'b1;
      run;
      @(posedge clk) hw_trg <= 1'b0;
      chk_rng(s, 4, 4);
      rdc(adcc_pkg::OFS_SC1, 8'h81);
   endtask

   // Verdict, reached from the main flow or the watchdog
   task results;
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main flow after six cycles of reset
   initial begin
      rst = 1'b1;
      {wr_s, rd_s, hw_trg, addr, wdata} = '0;
      level = 12'hA5C;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_single;
      t_active;
      t_clocks;
      t_cmp;
      t_lock;
      t_cont_hw;
      results;
   end
   // Watchdog at 40000 cycles, over thirty-five times the expected run of under 1100 cycles
   initial begin
      #1000000;
      num_errors++;
      results;
   end
endmodule
`default_nettype wire

// File: dv/adcc_ana_model.sv
// Analog input model feeding the converter core result.
// Assumes the result is only taken during the approximation phase.
`timescale 1ns/1ps
`default_nettype none
module adcc_ana_model (
   input  wire logic        clk_i,     // Bus clock
   input  wire logic        conv_on_i, // Converter powered
   input  wire logic        convert_i, // Approximation phase
   input  wire logic [11:0] level_i,   // Level on the input
   output logic      [11:0] result_o   // Result to the block
);
   logic [11:0] churn = 12'h000;
   // Churning value outside conversion so stale data never matches
   always @(posedge clk_i) churn <= churn + 12'h5A3;
   assign result_o = (convert_i && conv_on_i) ? level_i : ~churn;
endmodule
`default_nettype wire

// File: dv/adcc_props.sv
// Port checker of the converter control block.
// Assumes it is bound into adcc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adcc_props (
   input wire logic        core_clk_i,    // Bus clock
   input wire logic        sys_rst_i,     // Async reset
   input wire logic [3:0]  reg_addr_i,    // Register index
   input wire logic [7:0]  reg_wdata_i,   // Write data
   input wire logic        reg_wr_i,      // Write strobe
   input wire logic        reg_rd_i,      // Read strobe
   input wire logic [7:0]  reg_rdata_o,   // Read data
   input wire logic        conv_on_o,     // Converter powered
   input wire logic        sample_o,      // Sampling phase
   input wire logic        convert_o,     // Approx. phase
   input wire logic [4:0]  channel_o,     // Selected input
   input wire logic [1:0]  resolution_o,  // Mode to core
   input wire logic        low_power_o,   // Low-power mode
   input wire logic        irq_o,         // Done interrupt
   input wire logic [15:0] pin_disable_o  // Digital I/O off
);
   logic ien_q;
   logic trg_q;
   logic sc1_wr;
   logic clr_ev;
   // Shadow of interrupt enable and trigger source
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ien_q <= 1'b0;
         trg_q <= 1'b0;
      end else if (sc1_wr) begin
         ien_q <= reg_wdata_i[6];
      end else if (reg_wr_i && reg_addr_i == adcc_pkg::OFS_SC2) begin
         trg_q <= reg_wdata_i[6];
      end
   end
   // Events that must clear the done flag
   assign sc1_wr = reg_wr_i && reg_addr_i == adcc_pkg::OFS_SC1;
   assign clr_ev = sc1_wr || (reg_rd_i && reg_addr_i == adcc_pkg::OFS_RESL);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   a_sc2_reserved: assert property (reg_rd_i && reg_addr_i == 4'h1
      |=> reg_rdata_o[3:2] == 2'h0) else $error("reserved bits not zero");
   a_chan_update: assert property (sc1_wr
      |=> channel_o == $past(reg_wdata_i[4:0])) else $error("channel");
   a_off_power: assert property (conv_on_o == (channel_o != 5'h1F))
      else $error("power state wrong");
   a_off_idle: assert property (sc1_wr && reg_wdata_i[4:0] == 5'h1F
      |-> ##2 (!sample_o && !convert_o) [*6]) else $error("ran while off");
   a_sw_start: assert property (sc1_wr && reg_wdata_i[4:0] != 5'h1F
      && !trg_q |-> ##2 sample_o) else $error("no software start");
   a_phase_order: assert property ($rose(convert_o) |-> $past(sample_o))
      else $error("convert without sample");
   a_cfg_outputs: assert property (reg_wr_i && reg_addr_i == 4'h6
      |=> low_power_o == $past(reg_wdata_i[7])
      && resolution_o == $past(reg_wdata_i[3:2])) else $error("config");
   a_pin_disable: assert property (reg_wr_i && reg_addr_i == 4'h7
      |=> pin_disable_o[7:0] == $past(reg_wdata_i)) else $error("pins");
   a_irq_enable: assert property (irq_o |-> ien_q)
      else $error("interrupt while disabled");
   a_irq_clear: assert property (clr_ev && !convert_o |=> !irq_o)
      else $error("done not cleared");
   c_irq: cover property (sc1_wr ##[1:200] irq_o);
   c_conv: cover property ($fell(convert_o));
   c_hw: cover property ($rose(sample_o) && trg_q);
endmodule
bind adcc_top adcc_props i_adcc_props (.core_clk_i, .sys_rst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .conv_on_o, .sample_o,
   .convert_o, .channel_o, .resolution_o, .low_power_o, .irq_o,
   .pin_disable_o);
`default_nettype wire

// File: src/adcc_clkdiv.sv
// Converter clock divider producing one-cycle enable pulses.
// Assumes src_tick_i is a one-cycle enable on the core clock.
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv (
   input  wire logic       clk_i,      // Core clock
   input  wire logic       rst_i,      // Async reset, high
   input  wire logic       src_tick_i, // Input clock tick
   input  wire logic [1:0] div_sel_i,  // Divide 1,2,4,8
   output logic            tick_o      // Converter clock tick
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [2:0] lim;

   // Count source ticks up to the divide limit
   always_comb begin
      lim = 3'((4'h1 << div_sel_i) - 4'h1);
      tick_o = src_tick_i && (cnt == lim);
      next_cnt = cnt;
      if (src_tick_i) begin
         next_cnt = tick_o ? 3'h0 : 3'(cnt + 3'h1);
      end
   end

   // Divider counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// File: src/adcc_pkg.sv
// Constants, register map and types of the converter control block.
// Assumes one 40 MHz clock and a byte-wide register port.
// What this block does
// - Control-one write sets continuous mode, done interrupt and channel.
// - Config bit 7 selects low-power operation.
// - Config bits 6:5 divide the input clock; 00 divides by one.
// - Config bit 4 selects long sample time.
// - Config bits 3:2 select resolution; 10 gives 10-bit results.
// - Config bits 1:0 select input clock; 00 is the bus clock.
// - Control-two bit 7 shows a conversion in progress.
// - Control-two bit 6 picks trigger: 0 software, 1 hardware.
// - Control-two bit 5 enables the compare function.
// - Control-two bits 3:2 read zero; software writes bits 1:0 zero.
// - Control-one bit 7 is a read-only done flag set by hardware.
// - Control-one bit 6 enables the conversion-complete interrupt.
// - Control-one bit 5 selects continuous, else one per trigger.
// - Control-one bits 4:0 hold the channel; 00001 is input one.
// - High result byte read first; pair protected until low is read.
// - Compare value pair holds the threshold used by compare.
// - Set pin control bits disable digital I/O of matching pins.
// - Done flag clears on control-one write or low result read.
// - Interrupt asserts while done flag and its enable are set.
// - Software trigger: control-one write starts one or continuous.
// - Channel all ones turns converter off and ends continuous runs.
package adcc_pkg;
   // Register indices on the byte port
   localparam logic [3:0] OFS_SC1  = 4'h0;
   localparam logic [3:0] OFS_SC2  = 4'h1;
   localparam logic [3:0] OFS_RESH = 4'h2;
   localparam logic [3:0] OFS_RESL = 4'h3;
   localparam logic [3:0] OFS_CVH  = 4'h4;
   localparam logic [3:0] OFS_CVL  = 4'h5;
   localparam logic [3:0] OFS_CFG  = 4'h6;
   localparam logic [3:0] OFS_PIN1 = 4'h7;
   localparam logic [3:0] OFS_PIN2 = 4'h8;
   // Field positions
   localparam int CFG_LP   = 7;
   localparam int CFG_DIVH = 6;
   localparam int CFG_DIVL = 5;
   localparam int CFG_LSMP = 4;
   localparam int CFG_MODH = 3;
   localparam int CFG_MODL = 2;
   localparam int CFG_CKH  = 1;
   localparam int CFG_CKL  = 0;
   localparam int SC2_ACT  = 7;
   localparam int SC2_TRG  = 6;
   localparam int SC2_CFE  = 5;
   localparam int SC2_CGT  = 4;
   localparam int SC1_DONE = 7;
   localparam int SC1_IEN  = 6;
   localparam int SC1_CONT = 5;
   // Reset values
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_SC2 = 8'h00;
   localparam logic [4:0] CH_OFF  = 5'h1F;
   // Resolution codes
   localparam logic [1:0] MODE_8  = 2'h0;
   localparam logic [1:0] MODE_12 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;
   // Input clock codes
   localparam logic [1:0] CK_BUS  = 2'h0;
   localparam logic [1:0] CK_HALF = 2'h1;
   localparam logic [1:0] CK_ALT  = 2'h2;
   localparam logic [1:0] CK_ASYN = 2'h3;
   // Phase lengths in converter clock ticks
   localparam logic [4:0] SMP_SHORT = 5'h04;
   localparam logic [4:0] SMP_LONG  = 5'h18;
   localparam logic [4:0] CONV_XTRA = 5'h02;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMP = 2'b01,
      ST_CONV = 2'b11
   } adcc_state_t;
endpackage

// File: src/adcc_top.sv
// Control and register front end of a SAR converter.
// Assumes the analog core settles core_result_i by the end
// of the conversion phase; pins reach it via 3-flop syncs.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
   input  wire logic        core_clk_i,    // Bus clock
   input  wire logic        sys_rst_i,     // Async reset
   input  wire logic [3:0]  reg_addr_i,    // Register index
   input  wire logic [7:0]  reg_wdata_i,   // Write data
   input  wire logic        reg_wr_i,      // Write strobe
   input  wire logic        reg_rd_i,      // Read strobe
   output logic      [7:0]  reg_rdata_o,   // Read data
   input  wire logic        hw_trigger_i,  // Trigger pin
   input  wire logic        alt_clk_i,     // Alt clock pin
   input  wire logic        async_clk_i,   // Async clock pin
   input  wire logic [11:0] core_result_i, // Core result
   output logic             conv_on_o,     // Converter powered
   output logic             sample_o,      // Sampling phase
   output logic             convert_o,     // Approx. phase
   output logic      [4:0]  channel_o,     // Selected input
   output logic      [1:0]  resolution_o,  // Mode to core
   output logic             low_power_o,   // Low-power mode
   output logic             irq_o,         // Done interrupt
   output logic     [15:0]  pin_disable_o  // Digital I/O off
);
   // Register state
   logic [7:0]  cfg;
   logic [7:0]  next_cfg;
   logic [6:0]  sc2;
   logic [6:0]  next_sc2;
   logic        ien;
   logic        next_ien;
   logic        cont;
   logic        next_cont;
   logic [4:0]  chan;
   logic [4:0]  next_chan;
   logic [7:0]  cvh;
   logic [7:0]  next_cvh;
   logic [7:0]  cvl;
   logic [7:0]  next_cvl;
   logic [7:0]  pin1;
   logic [7:0]  next_pin1;
   logic [7:0]  pin2;
   logic [7:0]  next_pin2;
   logic [11:0] result;
   logic [11:0] next_result;
   logic        done;
   logic        next_done;
   logic        lock;
   logic        next_lock;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;

   // Sequencer state
   adcc_pkg::adcc_state_t state;
   adcc_pkg::adcc_state_t next_state;
   logic        active;
   logic        next_active;
   logic        restart;
   logic        next_restart;
   logic [4:0]  cnt;
   logic [4:0]  next_cnt;
   logic        half;
   logic        next_half;

   // Pin synchronisers and filtered levels
   logic [2:0]  trg_sy;
   logic [2:0]  alt_sy;
   logic [2:0]  asy_sy;
   logic        trg_lvl;
   logic        next_trg_lvl;
   logic        alt_lvl;
   logic        next_alt_lvl;
   logic        asy_lvl;
   logic        next_asy_lvl;

   // Decoded strobes and helper terms
   logic        wr_sc1;
   logic        rd_resh;
   logic        rd_resl;
   logic        trg_edge;
   logic        src_tick;
   logic        converter_clock;
   logic        hw_mode;
   logic        finish;
   logic        cmp_ok;
   logic        keep;
   logic [11:0] conv_val;
   logic [11:0] cmp_val;
   logic [4:0]  smp_len;
   logic [4:0]  cnv_len;

   // Result bits for a resolution code
   function automatic logic [4:0] mode_bits(
      input logic [1:0] m
   );
      unique case (m)
         adcc_pkg::MODE_12: mode_bits = 5'h0C;
         adcc_pkg::MODE_10: mode_bits = 5'h0A;
         default:           mode_bits = 5'h08;
      endcase
   endfunction

   // Right-justify a value to the resolution in use
   function automatic logic [11:0] fit(
      input logic [11:0] v,
      input logic [1:0]  m
   );
      unique case (m)
         adcc_pkg::MODE_12: fit = v;
         adcc_pkg::MODE_10: fit = {2'h0, v[11:2]};
         default:           fit = {4'h0, v[11:4]};
      endcase
   endfunction

   // Width-fitted compare threshold
   function automatic logic [11:0] thresh(
      input logic [7:0] h,
      input logic [7:0] l,
      input logic [1:0] m
   );
      unique case (m)
         adcc_pkg::MODE_12: thresh = {h[3:0], l};
         adcc_pkg::MODE_10: thresh = {2'h0, h[1:0], l};
         default:           thresh = {4'h0, l};
      endcase
   endfunction

   // Register port strobes
   assign wr_sc1  = reg_wr_i && reg_addr_i == adcc_pkg::OFS_SC1;
   assign rd_resh = reg_rd_i && reg_addr_i == adcc_pkg::OFS_RESH;
   assign rd_resl = reg_rd_i && reg_addr_i == adcc_pkg::OFS_RESL;
   assign hw_mode = sc2[adcc_pkg::SC2_TRG];

   // Three-flop pin capture; stage two feeds stage three and the level filter
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trg_sy <= 3'h0;
         alt_sy <= 3'h0;
         asy_sy <= 3'h0;
      end else begin
         trg_sy <= {trg_sy[1:0], hw_trigger_i};
         alt_sy <= {alt_sy[1:0], alt_clk_i};
         asy_sy <= {asy_sy[1:0], async_clk_i};
      end
   end

   // Accept a level once stages two and three agree
   always_comb begin
      next_trg_lvl = trg_lvl;
      next_alt_lvl = alt_lvl;
      next_asy_lvl = asy_lvl;
      if (trg_sy[1] == trg_sy[2]) begin
         next_trg_lvl = trg_sy[2];
      end
      if (alt_sy[1] == alt_sy[2]) begin
         next_alt_lvl = alt_sy[2];
      end
      if (asy_sy[1] == asy_sy[2]) begin
         next_asy_lvl = asy_sy[2];
      end
   end

   // Filtered pin levels
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trg_lvl <= 1'b0;
         alt_lvl <= 1'b0;
         asy_lvl <= 1'b0;
      end else begin
         trg_lvl <= next_trg_lvl;
         alt_lvl <= next_alt_lvl;
         asy_lvl <= next_asy_lvl;
      end
   end

   // Input clock source tick
   always_comb begin
      trg_edge = next_trg_lvl && !trg_lvl;
      next_half = !half;
      unique case (cfg[adcc_pkg::CFG_CKH:adcc_pkg::CFG_CKL])
         adcc_pkg::CK_BUS:  src_tick = 1'b1;
         adcc_pkg::CK_HALF: src_tick = half;
         adcc_pkg::CK_ALT:  src_tick = next_alt_lvl && !alt_lvl;
         adcc_pkg::CK_ASYN: src_tick = next_asy_lvl && !asy_lvl;
      endcase
   end

   // Converter clock divider
   adcc_clkdiv u_div (
      .clk_i      (core_clk_i),
      .rst_i      (sys_rst_i),
      .src_tick_i (src_tick),
      .div_sel_i  (cfg[adcc_pkg::CFG_DIVH:adcc_pkg::CFG_DIVL]),
      .tick_o     (converter_clock)
   );

   // Phase lengths and compare of the settling result
   always_comb begin
      smp_len = cfg[adcc_pkg::CFG_LSMP] ? adcc_pkg::SMP_LONG
                                         : adcc_pkg::SMP_SHORT;
      cnv_len = 5'(mode_bits(cfg[adcc_pkg::CFG_MODH:adcc_pkg::CFG_MODL])
                + adcc_pkg::CONV_XTRA);
      conv_val = fit(core_result_i,
                     cfg[adcc_pkg::CFG_MODH:adcc_pkg::CFG_MODL]);
      cmp_val = thresh(cvh, cvl,
                       cfg[adcc_pkg::CFG_MODH:adcc_pkg::CFG_MODL]);
      cmp_ok = sc2[adcc_pkg::SC2_CGT] ? (conv_val >= cmp_val)
                                       : (conv_val < cmp_val);
      finish = state == adcc_pkg::ST_CONV && converter_clock
               && cnt == 5'(cnv_len - 5'h01);
      // Compare off: every conversion counts
      keep = finish && (!sc2[adcc_pkg::SC2_CFE] || cmp_ok);
   end

   // Conversion sequencer
   always_comb begin
      next_state   = state;
      next_cnt     = cnt;
      next_active  = active;
      next_restart = 1'b0;
      unique case (state)
         adcc_pkg::ST_IDLE: begin
            if (restart || (hw_mode && trg_edge
                && chan != adcc_pkg::CH_OFF)) begin
               next_state  = adcc_pkg::ST_SAMP;
               next_cnt    = 5'h00;
               next_active = 1'b1;
            end
         end
         adcc_pkg::ST_SAMP: begin
            if (converter_clock) begin
               next_cnt = 5'(cnt + 5'h01);
               if (cnt == 5'(smp_len - 5'h01)) begin
                  next_state = adcc_pkg::ST_CONV;
                  next_cnt   = 5'h00;
               end
            end
         end
         adcc_pkg::ST_CONV: begin
            if (converter_clock) begin
               next_cnt = 5'(cnt + 5'h01);
            end
            if (finish) begin
               next_state   = adcc_pkg::ST_IDLE;
               next_active  = 1'b0;
               next_restart = cont;
            end
         end
      endcase
      // Control-one write aborts the sequence and restarts it in software mode
      if (wr_sc1) begin
         next_state  = adcc_pkg::ST_IDLE;
         next_active = 1'b0;
         next_cnt    = 5'h00;
         // Software trigger starts on the write; off code stops
         next_restart = !hw_mode
                        && reg_wdata_i[4:0] != adcc_pkg::CH_OFF;
      end else if (chan == adcc_pkg::CH_OFF) begin
         next_restart = 1'b0;
      end
   end

   // Sequencer registers
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state   <= adcc_pkg::ST_IDLE;
         cnt     <= 5'h00;
         active  <= 1'b0;
         restart <= 1'b0;
         half    <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         active  <= next_active;
         restart <= next_restart;
         half    <= next_half;
      end
   end

   // Register writes, result capture and flags
   always_comb begin
      next_cfg    = cfg;
      next_sc2    = sc2;
      next_ien    = ien;
      next_cont   = cont;
      next_chan   = chan;
      next_cvh    = cvh;
      next_cvl    = cvl;
      next_pin1   = pin1;
      next_pin2   = pin2;
      next_result = result;
      next_done   = done;
      next_lock   = lock;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            adcc_pkg::OFS_CFG: next_cfg = reg_wdata_i;
            adcc_pkg::OFS_SC2: next_sc2 = reg_wdata_i[6:0];
            adcc_pkg::OFS_SC1: begin
               // Done bit ignored on writes
               next_ien  = reg_wdata_i[adcc_pkg::SC1_IEN];
               next_cont = reg_wdata_i[adcc_pkg::SC1_CONT];
               next_chan = reg_wdata_i[4:0];
            end
            adcc_pkg::OFS_CVH:  next_cvh = reg_wdata_i;
            adcc_pkg::OFS_CVL:  next_cvl = reg_wdata_i;
            adcc_pkg::OFS_PIN1: next_pin1 = reg_wdata_i;
            adcc_pkg::OFS_PIN2: next_pin2 = reg_wdata_i;
            default: ;
         endcase
      end
      // High read freezes the pair until the low read
      if (rd_resh) begin
         next_lock = 1'b1;
      end
      if (rd_resl) begin
         next_lock = 1'b0;
      end
      // Clear first so that a same-cycle completion wins
      if (wr_sc1 || rd_resl) begin
         next_done = 1'b0;
      end
      if (keep && !lock) begin
         next_result = conv_val;
         next_done   = 1'b1;
      end
   end

   // Register file
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg    <= adcc_pkg::RST_CFG;
         sc2    <= adcc_pkg::RST_SC2[6:0];
         ien    <= 1'b0;
         cont   <= 1'b0;
         chan   <= adcc_pkg::CH_OFF;
         cvh    <= 8'h00;
         cvl    <= 8'h00;
         pin1   <= 8'h00;
         pin2   <= 8'h00;
         result <= 12'h000;
         done   <= 1'b0;
         lock   <= 1'b0;
      end else begin
         cfg    <= next_cfg;
         sc2    <= next_sc2;
         ien    <= next_ien;
         cont   <= next_cont;
         chan   <= next_chan;
         cvh    <= next_cvh;
         cvl    <= next_cvl;
         pin1   <= next_pin1;
         pin2   <= next_pin2;
         result <= next_result;
         done   <= next_done;
         lock   <= next_lock;
      end
   end

   // Read data mux; unmapped indices read zero
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            adcc_pkg::OFS_SC1:
               next_rdata = {done, ien, cont, chan};
            adcc_pkg::OFS_SC2:
               next_rdata = {active, sc2[adcc_pkg::SC2_TRG:4],
                             2'h0, sc2[1:0]};
            adcc_pkg::OFS_RESH: next_rdata = {4'h0, result[11:8]};
            adcc_pkg::OFS_RESL: next_rdata = result[7:0];
            adcc_pkg::OFS_CVH:  next_rdata = cvh;
            adcc_pkg::OFS_CVL:  next_rdata = cvl;
            adcc_pkg::OFS_CFG:  next_rdata = cfg;
            adcc_pkg::OFS_PIN1: next_rdata = pin1;
            adcc_pkg::OFS_PIN2: next_rdata = pin2;
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Outputs to core, pins and interrupt
   assign reg_rdata_o   = rdata;
   assign conv_on_o     = chan != adcc_pkg::CH_OFF;
   assign sample_o      = state == adcc_pkg::ST_SAMP;
   assign convert_o     = state == adcc_pkg::ST_CONV;
   assign channel_o     = chan;
   assign resolution_o  = cfg[adcc_pkg::CFG_MODH:adcc_pkg::CFG_MODL];
   assign low_power_o   = cfg[adcc_pkg::CFG_LP];
   assign irq_o         = done && ien;
   assign pin_disable_o = {pin2, pin1};
endmodule
`default_nettype wire
